/* test_tss_top.sv */
// self-checking bench of the sensor serial front end and alert logic
`timescale 1ns/100ps
`default_nettype none
module test_tss_top;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic conv_done = 1'b0; // one-cycle result strobe
   logic [15:0] conv_temp = 16'h0000;
   logic [15:0] conv_slew = 16'h0000; // rise rate result
   logic dout, doe, cs_n, sclk, line, alert_out;
   logic [15:0] config_word;
   logic [15:0] r; // last word read
   int fails = 0;
   int checked = 0;
   always #2 sys_clk = ~sys_clk;
   tss_top dut (.sys_clk(sys_clk), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk),
      .serial_data_io_in(line), .serial_data_io_out(dout), .serial_data_io_oe(doe),
      .conv_done(conv_done), .conv_temp(conv_temp), .conv_slew(conv_slew),
      .config_word(config_word), .alert_out(alert_out));
   tss_host host (.cs_n(cs_n), .sclk(sclk), .line(line), .dev_out(dout), .dev_oe(doe));
   // compare one value
   task chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // command word: no checksum, length field n
   function automatic logic [15:0] cmd(logic [3:0] n, logic inc, logic rd, logic [7:0] a);
      return {2'b00, n, inc, rd, a};
   endfunction
   task wr(input logic [7:0] a, input logic [15:0] d, input logic inc);
      host.start();
      host.word(cmd(4'h1, inc, 1'b0, a), 1'b1, r);
      host.word(d, 1'b1, r);
      host.stop();
   endtask
   task rd(input logic [7:0] a);
      host.start();
      host.word(cmd(4'h1, 1'b0, 1'b1, a), 1'b1, r);
      host.word(16'h0000, 1'b0, r);
      host.stop();
   endtask
   // present one conversion result, driven just after the edge
   task conv(input logic [15:0] t);
      @(posedge sys_clk) #1 conv_temp = t;
      conv_done = 1'b1;
      @(posedge sys_clk) #1 conv_done = 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask
   task t_reset();
      rd(tss_pkg::ADDR_CFG);
      chk("cfg", r, tss_pkg::RST_CFG);
      host.start();
      host.word(cmd(4'h3, 1'b1, 1'b1, tss_pkg::ADDR_LOW), 1'b1, r);
      host.word(16'h0000, 1'b0, r);
      chk("low", r, tss_pkg::RST_LOW);
      host.word(16'h0000, 1'b0, r);
      chk("high", r, tss_pkg::RST_HIGH);
      host.word(16'h0000, 1'b0, r);
      chk("hyst", r, tss_pkg::RST_HYST);
      host.stop();
      $display("test reset done");
   endtask
   task t_regs();
      wr(tss_pkg::ADDR_HIGH, 16'h2A00, 1'b0);
      rd(tss_pkg::ADDR_HIGH);
      chk("high wr", r, 16'h2A00);
      wr(8'h20, 16'h1234, 1'b0);
      rd(8'h20);
      chk("unmapped", r, 16'h0000);
      wr(tss_pkg::ADDR_CFG, 16'h0004, 1'b1);
      chk("cfg inc", config_word, tss_pkg::RST_CFG);
      $display("test regs done");
   endtask
   // comparator style is the reset default; high deadband 0Ah*128
   task t_comp();
      conv(16'h2B00);
      chk("alert hi", alert_out, 1'b1);
      rd(tss_pkg::ADDR_STAT);
      chk("alert rd", alert_out, 1'b1);
      conv(16'h2000);
      chk("alert lo", alert_out, 1'b0);
      conv(16'h2B00);
      wr(tss_pkg::ADDR_AEN, 16'h0006, 1'b0);
      chk("alert mask", alert_out, 1'b0);
      wr(tss_pkg::ADDR_AEN, tss_pkg::RST_AEN, 1'b0);
      $display("test comparator done");
   endtask
   task t_int();
      conv(16'h2B00);
      wr(tss_pkg::ADDR_CFG, 16'h0004, 1'b0);
      chk("cfg", config_word, 16'h0004);
      chk("alert sw", alert_out, 1'b0);
      rd(tss_pkg::ADDR_STAT);
      chk("stat sw", r, 16'h0000);
      conv(16'h2B00);
      chk("alert hi", alert_out, 1'b1);
      rd(tss_pkg::ADDR_STAT);
      chk("stat hi", r, 16'h0092);
      chk("alert rd", alert_out, 1'b0);
      conv(16'h2C00);
      chk("alert db", alert_out, 1'b0);
      conv(16'h2000);
      chk("alert fall", alert_out, 1'b1);
      rd(tss_pkg::ADDR_STAT);
      chk("stat fall", r, 16'h0090);
      wr(tss_pkg::ADDR_AEN, 16'h0006, 1'b0);
      conv(16'h2B00);
      chk("alert mask", alert_out, 1'b0);
      rd(tss_pkg::ADDR_STAT);
      chk("stat mask", r, 16'h0092);
      conv(16'hF000);
      rd(tss_pkg::ADDR_STAT);
      chk("stat low", r, 16'h0099);
      @(posedge sys_clk) #1 conv_slew = 16'h0600; // above the rate limit
      conv(16'hF000);
      rd(tss_pkg::ADDR_STAT);
      chk("stat slew", r, 16'h00A5);
      $display("test interrupt done");
   endtask
   task t_fmt();
      conv(16'h0C83);
      rd(tss_pkg::ADDR_TEMP);
      chk("temp", r, 16'h0C80);
      wr(tss_pkg::ADDR_CFG, 16'h0080, 1'b0);
      chk("srst cfg", config_word, tss_pkg::RST_CFG);
      chk("srst oe", doe, 1'b0);
      rd(tss_pkg::ADDR_HIGH);
      chk("srst high", r, tss_pkg::RST_HIGH);
      $display("test format done");
   endtask
   task test_done();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge sys_clk);
      #1 reset_n = 1'b1;
      repeat (4) @(posedge sys_clk);
      t_reset();
      t_regs();
      t_comp();
      t_int();
      t_fmt();
      test_done();
   end
   // cuts a hang short well past the expected run
   initial begin
      #300000;
      fails++;
      test_done();
   end
endmodule // test_tss_top
`default_nettype wire

/* tss_host.sv */
// host side serial controller model for the sensor front end
`timescale 1ns/100ps
`default_nettype none
module tss_host (
   output logic cs_n, // select, low in a transaction
   output logic sclk, // serial clock, still outside frames
   output logic line, // resolved data line level
   input wire logic dev_out, // device drive value
   input wire logic dev_oe // device drives the line
);
   logic hbit = 1'b0; // host drive value
   logic hoe = 1'b0; // host drives the line
   logic last = 1'b0; // last resolved level
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
   end
   // an undriven line shows the inverse of its last level, so stale data never passes
   always_comb begin
      line = dev_oe ? dev_out : (hoe ? hbit : ~last);
   end
   // remember the level seen at each falling edge
   always @(negedge sclk) begin
      last <= line;
   end
   // each frame opens on a fresh select fall
   task start();
      cs_n = 1'b0;
      #100;
   endtask
   // release the line, then raise select between frames
   task stop();
      hoe = 1'b0;
      #100;
      cs_n = 1'b1;
      #300;
   endtask
   // one 16-bit word, MSB first, host changes data on the fall for rising sampling
   task word(input logic [15:0] w, input logic drv, output logic [15:0] r);
      for (int i = 15; i >= 0; i--) begin
         hbit = w[i];
         hoe = drv;
         #62.5 sclk = 1'b1;
         r[i] = line;
         #62.5 sclk = 1'b0;
      end
   endtask
endmodule // tss_host
`default_nettype wire

/* tss_pkg.sv */
// shared constants and types of the temperature sensor serial front end
package tss_pkg;
   // register addresses
   localparam logic [7:0] ADDR_TEMP = 8'h00;
   localparam logic [7:0] ADDR_SLEW = 8'h01;
   localparam logic [7:0] ADDR_STAT = 8'h02;
   localparam logic [7:0] ADDR_CFG = 8'h03;
   localparam logic [7:0] ADDR_AEN = 8'h04;
   localparam logic [7:0] ADDR_LOW = 8'h05;
   localparam logic [7:0] ADDR_HIGH = 8'h06;
   localparam logic [7:0] ADDR_HYST = 8'h07;
   localparam logic [7:0] ADDR_SLIM = 8'h08;
   localparam logic [7:0] ADDR_UID1 = 8'h09;
   localparam logic [7:0] ADDR_UID3 = 8'h0B;
   localparam logic [7:0] ADDR_DEVID = 8'h0C;
   // reset values
   localparam logic [15:0] RST_CFG = 16'h0006;
   localparam logic [15:0] RST_AEN = 16'h0016;
   localparam logic [15:0] RST_LOW = 16'hF380;
   localparam logic [15:0] RST_HIGH = 16'h2A80;
   localparam logic [15:0] RST_HYST = 16'h0A0A;
   localparam logic [15:0] RST_SLIM = 16'h0500;
   // command word fields
   localparam int CMD_CRC_BIT = 14;
   localparam int CMD_INC_BIT = 9;
   localparam int CMD_RD_BIT = 8;
   localparam logic [3:0] CRC_MAX_LEN = 4'hA;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_SEED = 16'hFFFF;
   // status fields: levels low/high/slew at 0..2, event latches at 3..5
   localparam int ST_EVT = 3;
   localparam int ST_CRC = 6;
   localparam int ST_DRDY = 7;
   // configuration fields
   localparam int CFG_INT_COMP = 1;
   localparam int CFG_SRST = 7;
   // temperature keeps two zero bits at the bottom
   localparam logic [15:0] TEMP_MASK = 16'hFFFC;
   // one deadband step (1 degree) in result units
   localparam int HYST_SHIFT = 7;
   typedef enum logic [1:0] {TSS_CMD, TSS_DATA, TSS_CRC, TSS_IDLE} tss_phase_t;
endpackage

/* tss_top.sv */
// serial target, register file and alert logic of the temperature sensor
//
// Overview of operation
// - alert select zero means interrupt style
// - style change clears status and alert
// - above high limit sets level, latch, alert
// - interrupt style status read clears latches, alert
// - high deadband from upper hysteresis byte
// - dropping below deadband clears level, sets latch
// - masked event latches but never alerts
// - low channel behaves alike, mirrored; slew alike with no deadband
// - comparator alert is OR of enabled levels
// - comparator level clears below deadband threshold
// - comparator mask removal drops contribution at once
// - temperature is 14 bits, left aligned
// - words go MSB byte and bit first
// - drive on falling, sample on rising edge
// - unchecked written word commits on 16th rising edge
// - soft reset after 16th edge, silent till select
// - command word, data block, optional checksum
// - command bit fields, length gates checksum
// - bit 9 advances register pointer per word
// - bit 8 selects who drives data line
// - unmapped writes dropped, unmapped reads zero
// - burst reads never clear latches, only data ready on temperature
// - configuration accepts single plain writes only
// - checksum is CRC 1021h seeded FFFFh
`timescale 1ns/100ps
`default_nettype none
module tss_top #(
   parameter logic [15:0] DEVICE_ID = 16'h5A5A, // arbitrary value
   parameter logic [15:0] UNIQUE_ID = 16'hC3C3 // arbitrary value
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic cs_n, // select pin, async
   input wire logic sclk, // serial clock pin, async
   input wire logic serial_data_io_in, // data line level
   output logic serial_data_io_out, // data line drive value
   output logic serial_data_io_oe, // high while we drive the line
   input wire logic conv_done, // one-cycle pulse, same domain
   input wire logic [15:0] conv_temp, // new result, left aligned
   input wire logic [15:0] conv_slew, // new rise rate result
   output logic [15:0] config_word, // configuration for the converter
   output logic alert_out // alert pin, active high
);
   // element count of the write holding buffer
   localparam int BUF_WORDS = 10;
   // refuse a holding buffer that cannot take the longest checked block
   if (BUF_WORDS < int'(tss_pkg::CRC_MAX_LEN)) begin : g_buf_chk
      $error("holding buffer too small");
   end

   // checksum advance by one bit
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
      crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? tss_pkg::CRC_POLY : 16'h0000);
   endfunction

   // writable register test, used by live and buffered writes
   function automatic logic wr_ok(input logic [7:0] a);
      wr_ok = (a >= tss_pkg::ADDR_CFG) && (a <= tss_pkg::ADDR_SLIM);
   endfunction

   // synchronisers: stage 1 feeds only stage 2
   logic cs_s1_reg, cs_s2_reg, cs_s3_reg, sck_s1_reg, sck_s2_reg, sck_s3_reg, sio_s1_reg, sio_s2_reg;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         {cs_s1_reg, cs_s2_reg, cs_s3_reg} <= 3'h7;
         {sck_s1_reg, sck_s2_reg, sck_s3_reg, sio_s1_reg, sio_s2_reg} <= 5'h00;
      end else begin
         {cs_s1_reg, cs_s2_reg, cs_s3_reg} <= {cs_n, cs_s1_reg, cs_s2_reg};
         {sck_s1_reg, sck_s2_reg, sck_s3_reg} <= {sclk, sck_s1_reg, sck_s2_reg};
         {sio_s1_reg, sio_s2_reg} <= {serial_data_io_in, sio_s1_reg};
      end
   end
   wire cs_fall = cs_s3_reg && !cs_s2_reg; // fresh transaction
   wire sck_rise = !sck_s3_reg && sck_s2_reg && !cs_s2_reg; // sample edge
   wire sck_fall = sck_s3_reg && !sck_s2_reg && !cs_s2_reg; // drive edge

   // register file state
   logic [15:0] temp_reg, slew_reg, stat_reg, cfg_reg, aen_reg, low_reg, high_reg, hyst_reg, slim_reg;
   logic [15:0] temp_next, slew_next, stat_next, cfg_next, aen_next, low_next, high_next, hyst_next, slim_next;
   logic alert_reg, alert_next;

   // register read mux; holes read zero
   function automatic logic [15:0] rd_word(input logic [7:0] a);
      case (a)
         tss_pkg::ADDR_TEMP: rd_word = temp_reg;
         tss_pkg::ADDR_SLEW: rd_word = slew_reg;
         tss_pkg::ADDR_STAT: rd_word = stat_reg;
         tss_pkg::ADDR_CFG: rd_word = cfg_reg;
         tss_pkg::ADDR_AEN: rd_word = aen_reg;
         tss_pkg::ADDR_LOW: rd_word = low_reg;
         tss_pkg::ADDR_HIGH: rd_word = high_reg;
         tss_pkg::ADDR_HYST: rd_word = hyst_reg;
         tss_pkg::ADDR_SLIM: rd_word = slim_reg;
         tss_pkg::ADDR_DEVID: rd_word = DEVICE_ID;
         default: rd_word = (a >= tss_pkg::ADDR_UID1 && a <= tss_pkg::ADDR_UID3) ? UNIQUE_ID : 16'h0000;
      endcase
   endfunction

   // serial engine state
   tss_pkg::tss_phase_t phase_reg, phase_next;
   logic [3:0] bit_cnt_reg, bit_cnt_next, word_cnt_reg, word_cnt_next, len_reg, len_next;
   logic [15:0] rx_reg, rx_next, tx_reg, tx_next, crc_reg, crc_next;
   logic [7:0] addr_reg, addr_next, dr_addr_reg, dr_addr_next;
   logic inc_reg, inc_next, rd_reg, rd_next, crc_on_reg, crc_on_next;
   logic sio_out_reg, sio_out_next, sio_oe_reg, sio_oe_next;
   logic [15:0] wbuf_reg [BUF_WORDS];
   logic [15:0] wbuf_next [BUF_WORDS];
   logic drain_reg, drain_next;
   logic [3:0] dr_cnt_reg, dr_cnt_next;
   // strobes from engine to register file
   logic wr_en, wr_cfg_ok, clr_stat, clr_drdy, crc_fail, srst;
   logic [7:0] wr_addr, rd_addr;
   logic [15:0] wr_data, rx_word;
   logic bit_in, last_word;

   // serial engine next state
   always_comb begin
      phase_next = phase_reg;
      bit_cnt_next = bit_cnt_reg;
      word_cnt_next = word_cnt_reg;
      len_next = len_reg;
      rx_next = rx_reg;
      tx_next = tx_reg;
      crc_next = crc_reg;
      addr_next = addr_reg;
      inc_next = inc_reg;
      rd_next = rd_reg;
      crc_on_next = crc_on_reg;
      sio_out_next = sio_out_reg;
      sio_oe_next = sio_oe_reg;
      wbuf_next = wbuf_reg;
      drain_next = drain_reg;
      dr_cnt_next = dr_cnt_reg;
      dr_addr_next = dr_addr_reg;
      wr_en = 1'b0;
      wr_cfg_ok = 1'b0;
      wr_addr = addr_reg;
      wr_data = 16'h0000;
      clr_stat = 1'b0;
      clr_drdy = 1'b0;
      crc_fail = 1'b0;
      rd_addr = addr_reg;
      rx_word = {rx_reg[14:0], sio_s2_reg};
      // checksum covers what travels on the line in either direction
      bit_in = (rd_reg && phase_reg != tss_pkg::TSS_CMD) ? sio_out_reg : sio_s2_reg;
      last_word = crc_on_reg && (word_cnt_reg == len_reg - 4'h1);
      if (drain_reg) begin
         // checksum passed: commit held words one per cycle, never config
         wr_en = 1'b1;
         wr_addr = dr_addr_reg;
         wr_data = wbuf_reg[dr_cnt_reg];
         dr_cnt_next = dr_cnt_reg + 4'h1;
         dr_addr_next = dr_addr_reg + {7'h00, inc_reg};
         drain_next = (dr_cnt_reg != len_reg - 4'h1);
      end
      if (cs_fall) begin
         // every transaction opens with a command word
         phase_next = tss_pkg::TSS_CMD;
         bit_cnt_next = 4'h0;
         crc_next = tss_pkg::CRC_SEED;
         sio_oe_next = 1'b0;
      end else if (cs_s2_reg) begin
         sio_oe_next = 1'b0; // released while deselected
      end else if (sck_rise && phase_reg != tss_pkg::TSS_IDLE) begin
         rx_next = rx_word; // MSB arrives first
         bit_cnt_next = bit_cnt_reg + 4'h1;
         if (phase_reg != tss_pkg::TSS_CRC) begin
            crc_next = crc_step(crc_reg, bit_in);
         end
         if (bit_cnt_reg == 4'hF) begin
            case (phase_reg)
               tss_pkg::TSS_CMD: begin
                  // decode fields; bit 15 ignored
                  addr_next = rx_word[7:0];
                  inc_next = rx_word[tss_pkg::CMD_INC_BIT];
                  rd_next = rx_word[tss_pkg::CMD_RD_BIT];
                  len_next = rx_word[13:10];
                  crc_on_next = rx_word[tss_pkg::CMD_CRC_BIT] && rx_word[13:10] != 4'h0
                     && rx_word[13:10] <= tss_pkg::CRC_MAX_LEN;
                  word_cnt_next = 4'h0;
                  phase_next = tss_pkg::TSS_DATA;
                  rd_addr = rx_word[7:0];
                  if (rx_word[tss_pkg::CMD_RD_BIT]) begin
                     tx_next = rd_word(rx_word[7:0]);
                     clr_stat = !rx_word[tss_pkg::CMD_INC_BIT] && rx_word[7:0] == tss_pkg::ADDR_STAT;
                     clr_drdy = rx_word[7:0] == tss_pkg::ADDR_TEMP || clr_stat;
                  end
               end
               tss_pkg::TSS_DATA: begin
                  word_cnt_next = word_cnt_reg + 4'h1;
                  rd_addr = inc_reg ? addr_reg + 8'h01 : addr_reg; // pointer step
                  addr_next = rd_addr;
                  if (!rd_reg && crc_on_reg) begin
                     wbuf_next[word_cnt_reg] = rx_word; // held until checksum
                  end else if (!rd_reg) begin
                     // commit on the 16th rising edge
                     wr_en = 1'b1;
                     wr_data = rx_word;
                     wr_cfg_ok = !inc_reg;
                  end else begin
                     tx_next = rd_word(rd_addr);
                     clr_stat = !inc_reg && rd_addr == tss_pkg::ADDR_STAT;
                     clr_drdy = rd_addr == tss_pkg::ADDR_TEMP || clr_stat;
                  end
                  if (last_word) begin
                     phase_next = tss_pkg::TSS_CRC;
                     tx_next = crc_next;
                     clr_stat = 1'b0;
                     clr_drdy = 1'b0;
                  end
               end
               default: begin
                  // checksum word: compare on writes, stop on both
                  phase_next = tss_pkg::TSS_IDLE;
                  if (!rd_reg && rx_word == crc_reg) begin
                     drain_next = 1'b1;
                     dr_cnt_next = 4'h0;
                     dr_addr_next = addr_reg - (inc_reg ? {4'h0, len_reg} : 8'h00);
                  end else if (!rd_reg) begin
                     crc_fail = 1'b1;
                  end
               end
            endcase
         end
      end else if (sck_fall && rd_reg && (phase_reg == tss_pkg::TSS_DATA || phase_reg == tss_pkg::TSS_CRC)) begin
         // drive next bit after the command word
         sio_out_next = tx_reg[15];
         tx_next = {tx_reg[14:0], 1'b0};
         sio_oe_next = 1'b1;
      end
      srst = wr_en && wr_cfg_ok && wr_addr == tss_pkg::ADDR_CFG && wr_data[tss_pkg::CFG_SRST];
      if (srst) begin
         // silent until the next select fall
         phase_next = tss_pkg::TSS_IDLE;
         sio_oe_next = 1'b0;
      end
   end

   // serial engine registers
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_reg <= tss_pkg::TSS_IDLE;
         {bit_cnt_reg, word_cnt_reg, len_reg, dr_cnt_reg} <= 16'h0000;
         {rx_reg, tx_reg} <= 32'h0000_0000;
         crc_reg <= tss_pkg::CRC_SEED;
         {addr_reg, dr_addr_reg} <= 16'h0000;
         {inc_reg, rd_reg, crc_on_reg, sio_out_reg, sio_oe_reg, drain_reg} <= 6'h00;
         wbuf_reg <= '{default: 16'h0000};
      end else begin
         phase_reg <= phase_next;
         {bit_cnt_reg, word_cnt_reg, len_reg, dr_cnt_reg} <= {bit_cnt_next, word_cnt_next, len_next, dr_cnt_next};
         {rx_reg, tx_reg} <= {rx_next, tx_next};
         crc_reg <= crc_next;
         {addr_reg, dr_addr_reg} <= {addr_next, dr_addr_next};
         {inc_reg, rd_reg, crc_on_reg} <= {inc_next, rd_next, crc_on_next};
         {sio_out_reg, sio_oe_reg, drain_reg} <= {sio_out_next, sio_oe_next, drain_next};
         wbuf_reg <= wbuf_next;
      end
   end

   // alert evaluation terms
   logic mode_chg;
   logic [2:0] set_c, clr_c, lvl;
   logic signed [16:0] hi_thr, lo_thr, t_s;

   // register file and alert next state
   always_comb begin
      temp_next = temp_reg;
      slew_next = slew_reg;
      stat_next = stat_reg;
      cfg_next = cfg_reg;
      aen_next = aen_reg;
      low_next = low_reg;
      high_next = high_reg;
      hyst_next = hyst_reg;
      slim_next = slim_reg;
      mode_chg = 1'b0;
      lvl = stat_reg[2:0];
      t_s = {conv_temp[15], conv_temp[15:2], 2'b00};
      // deadbands: high from upper byte, low from lower byte
      hi_thr = {high_reg[15], high_reg} - (17'(hyst_reg[15:8]) << tss_pkg::HYST_SHIFT);
      lo_thr = {low_reg[15], low_reg} + (17'(hyst_reg[7:0]) << tss_pkg::HYST_SHIFT);
      // temperature limits compare signed, or a positive result would look below a negative low limit
      set_c = {conv_slew > slim_reg, t_s > $signed({high_reg[15], high_reg}), t_s < $signed({low_reg[15], low_reg})};
      clr_c = {conv_slew < slim_reg, t_s < hi_thr, t_s > lo_thr};
      if (wr_en && wr_ok(wr_addr)) begin
         // unmapped and read-only targets are dropped
         case (wr_addr)
            tss_pkg::ADDR_CFG: begin
               if (wr_cfg_ok) begin
                  cfg_next = wr_data;
                  mode_chg = wr_data[tss_pkg::CFG_INT_COMP] != cfg_reg[tss_pkg::CFG_INT_COMP];
               end
            end
            tss_pkg::ADDR_AEN: aen_next = wr_data;
            tss_pkg::ADDR_LOW: low_next = wr_data;
            tss_pkg::ADDR_HIGH: high_next = wr_data;
            tss_pkg::ADDR_HYST: hyst_next = wr_data;
            default: slim_next = wr_data;
         endcase
      end
      if (mode_chg) begin
         stat_next = 16'h0000; // style switch wipes status
      end
      if (clr_stat) begin
         stat_next[tss_pkg::ST_DRDY:tss_pkg::ST_EVT] = 5'h00; // read clears latches
      end
      if (clr_drdy) begin
         stat_next[tss_pkg::ST_DRDY] = 1'b0;
      end
      if (conv_done) begin
         // new result, low bits forced zero; sets win over clears
         temp_next = conv_temp & tss_pkg::TEMP_MASK;
         slew_next = conv_slew;
         stat_next[tss_pkg::ST_DRDY] = 1'b1;
         for (int i = 0; i < 3; i++) begin
            // cross into or out of the band; latch even when masked
            if (!lvl[i] && set_c[i]) begin
               lvl[i] = 1'b1;
               stat_next[tss_pkg::ST_EVT + i] = 1'b1;
            end else if (lvl[i] && clr_c[i]) begin
               lvl[i] = 1'b0;
               stat_next[tss_pkg::ST_EVT + i] = 1'b1;
            end
         end
         stat_next[2:0] = lvl;
      end
      if (crc_fail) begin
         stat_next[tss_pkg::ST_CRC] = 1'b1;
      end
      if (cfg_next[tss_pkg::CFG_INT_COMP]) begin
         // comparator: enabled levels only, reads leave it alone
         alert_next = |(stat_next[2:0] & aen_next[5:3]);
      end else begin
         // interrupt: enabled latches
         alert_next = |(stat_next[5:3] & aen_next[5:3]) | (stat_next[tss_pkg::ST_CRC] & aen_next[tss_pkg::ST_CRC]);
      end
      if (srst) begin
         // soft reset brings every register to its reset value
         {temp_next, slew_next, stat_next} = 48'h0;
         {cfg_next, aen_next, low_next} = {tss_pkg::RST_CFG, tss_pkg::RST_AEN, tss_pkg::RST_LOW};
         {high_next, hyst_next, slim_next} = {tss_pkg::RST_HIGH, tss_pkg::RST_HYST, tss_pkg::RST_SLIM};
         alert_next = 1'b0;
      end
   end

   // register file flops
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         {temp_reg, slew_reg, stat_reg} <= 48'h0;
         {cfg_reg, aen_reg, low_reg} <= {tss_pkg::RST_CFG, tss_pkg::RST_AEN, tss_pkg::RST_LOW};
         {high_reg, hyst_reg, slim_reg} <= {tss_pkg::RST_HIGH, tss_pkg::RST_HYST, tss_pkg::RST_SLIM};
         alert_reg <= 1'b0;
      end else begin
         {temp_reg, slew_reg, stat_reg} <= {temp_next, slew_next, stat_next};
         {cfg_reg, aen_reg, low_reg} <= {cfg_next, aen_next, low_next};
         {high_reg, hyst_reg, slim_reg} <= {high_next, hyst_next, slim_next};
         alert_reg <= alert_next;
      end
   end

   assign serial_data_io_out = sio_out_reg;
   assign serial_data_io_oe = sio_oe_reg;
   assign config_word = cfg_reg;
   assign alert_out = alert_reg;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   property p_int_alert;
      !cfg_reg[1] |-> alert_reg == (|(stat_reg[5:3] & aen_reg[5:3]) | (stat_reg[6] & aen_reg[6]));
   endproperty
   a_int_alert: assert property (p_int_alert) else $error("interrupt alert mismatch");
   property p_cmp_alert;
      cfg_reg[1] |-> alert_reg == |(stat_reg[2:0] & aen_reg[5:3]);
   endproperty
   a_cmp_alert: assert property (p_cmp_alert) else $error("comparator alert mismatch");
   property p_mode_clr;
      (mode_chg && !conv_done && !crc_fail) |=> (stat_reg == 16'h0000 && !alert_reg);
   endproperty
   a_mode_clr: assert property (p_mode_clr) else $error("style change left status");
   wire lvl_before_hi = stat_reg[1]; // high level before this conversion
   property p_high_set;
      (conv_done && !lvl_before_hi && t_s > $signed({high_reg[15], high_reg}) && !srst && !mode_chg)
         |=> stat_reg[1] && stat_reg[4];
   endproperty
   a_high_set: assert property (p_high_set) else $error("high crossing not latched");
   property p_rd_clr;
      (clr_stat && !cfg_next[1] && !conv_done && !crc_fail && !srst) |=> !alert_reg && stat_reg[5:3] == 3'h0;
   endproperty
   a_rd_clr: assert property (p_rd_clr) else $error("status read kept alert");
   property p_commit;
      (wr_en && wr_addr == tss_pkg::ADDR_HIGH && !srst) |=> high_reg == $past(wr_data);
   endproperty
   a_commit: assert property (p_commit) else $error("write not committed");
   property p_srst;
      srst |=> (phase_reg == tss_pkg::TSS_IDLE && !sio_oe_reg && cfg_reg == tss_pkg::RST_CFG);
   endproperty
   a_srst: assert property (p_srst) else $error("soft reset incomplete");
   property p_no_drive;
      (phase_reg == tss_pkg::TSS_CMD || !rd_reg) |-> !sio_oe_reg;
   endproperty
   a_no_drive: assert property (p_no_drive) else $error("line driven on write");
   property p_cfg_burst;
      (wr_en && wr_addr == tss_pkg::ADDR_CFG && !wr_cfg_ok) |=> $stable(cfg_reg);
   endproperty
   a_cfg_burst: assert property (p_cfg_burst) else $error("burst changed config");
endmodule // tss_top
`default_nettype wire
